// ===== design/lct_pkg.sv
// Constants and types of the DDR read latency descriptor
package lct_pkg;

  // ***************************************************
  // Geometry
  // ***************************************************
  localparam int LCT_BYTES = 44;
  localparam int LCT_AW = 6;
  localparam int LCT_NROWS = 4;
  localparam int LCT_ROW0 = 12;
  localparam int LCT_ROWLEN = 8;
  localparam int LCT_FLD_FREQ = 0;
  localparam int LCT_FLD_CODE = 1;
  localparam int LCT_FLD_MODE = 2;
  localparam int LCT_FLD_DUM = 3;
  localparam int LCT_CMD_STRIDE = 2;

  // ***************************************************
  // Byte offsets inside the descriptor
  // ***************************************************
  localparam logic [5:0] LCT_OFF_PID = 6'h00;
  localparam logic [5:0] LCT_OFF_LEN = 6'h01;
  localparam logic [5:0] LCT_OFF_HF = 6'h04;
  localparam logic [5:0] LCT_OFF_HC = 6'h05;
  localparam logic [5:0] LCT_OFF_FAST3 = 6'h06;
  localparam logic [5:0] LCT_OFF_FAST4 = 6'h07;
  localparam logic [5:0] LCT_OFF_DUAL3 = 6'h08;
  localparam logic [5:0] LCT_OFF_DUAL4 = 6'h09;
  localparam logic [5:0] LCT_OFF_QUAD3 = 6'h0a;
  localparam logic [5:0] LCT_OFF_QUAD4 = 6'h0b;
  localparam logic [5:0] LCT_OFF_ROW2 = 6'h0c;
  localparam logic [5:0] LCT_OFF_ROW3 = 6'h14;
  localparam logic [5:0] LCT_OFF_ROW4 = 6'h1c;
  localparam logic [5:0] LCT_OFF_ROW5 = 6'h24;

  // ***************************************************
  // Byte values
  // ***************************************************
  localparam logic [7:0] LCT_PID = 8'h9a;
  localparam logic [7:0] LCT_LEN = 8'h2a;
  localparam logic [7:0] LCT_NROW_B = 8'h05;
  localparam logic [7:0] LCT_RLEN_B = 8'h08;
  localparam logic [7:0] LCT_ASC_F = 8'h46;
  localparam logic [7:0] LCT_ASC_C = 8'h43;
  localparam logic [7:0] LCT_OP_FAST3 = 8'h0d;
  localparam logic [7:0] LCT_OP_FAST4 = 8'h0e;
  localparam logic [7:0] LCT_OP_DUAL3 = 8'hbd;
  localparam logic [7:0] LCT_OP_DUAL4 = 8'hbe;
  localparam logic [7:0] LCT_OP_QUAD3 = 8'hed;
  localparam logic [7:0] LCT_OP_QUAD4 = 8'hee;
  localparam logic [7:0] LCT_F50 = 8'h32;
  localparam logic [7:0] LCT_F66 = 8'h42;
  localparam logic [7:0] LCT_FILL = 8'hff;

  // Descriptor contents: header, then four rows
  localparam logic [7:0] LCT_ROM [LCT_BYTES] = '{
    LCT_PID, LCT_LEN, LCT_NROW_B, LCT_RLEN_B,
    LCT_ASC_F, LCT_ASC_C, LCT_OP_FAST3, LCT_OP_FAST4,
    LCT_OP_DUAL3, LCT_OP_DUAL4, LCT_OP_QUAD3, LCT_OP_QUAD4,
    LCT_F50, 8'h03, 8'h04, 8'h01, 8'h02, 8'h02, 8'h01, 8'h03,
    LCT_F66, 8'h00, 8'h04, 8'h02, 8'h02, 8'h04, 8'h01, 8'h06,
    LCT_F66, 8'h01, 8'h04, 8'h04, 8'h02, 8'h05, 8'h01, 8'h07,
    LCT_F66, 8'h02, 8'h04, 8'h05, 8'h02, 8'h06, 8'h01, 8'h08
  };

  // ***************************************************
  // Types
  // ***************************************************
  typedef enum logic [1:0] {
    LCT_CMD_FAST,
    LCT_CMD_DUAL,
    LCT_CMD_QUAD,
    LCT_CMD_NONE
  } lct_cmd_t;

  typedef enum logic {
    LCT_RD_IDLE,
    LCT_RD_FETCH
  } lct_rd_t;

endpackage

// ===== design/lct_rom.sv
// Descriptor storage with registered read data
`timescale 1ns/1ns
module lct_rom
  import lct_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  input wire logic [LCT_AW-1:0] addr_i,
  output logic [7:0] data_o
);

  // ***************************************************
  // Read port
  // ***************************************************
  // Out-of-range offsets read as erased bytes
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_o <= 8'h00;
    end else if (en_i) begin
      if (int'(addr_i) < LCT_BYTES) begin
        data_o <= LCT_ROM[addr_i];
      end else begin
        data_o <= LCT_FILL;
      end
    end
  end

endmodule // lct_rom

// ===== design/lct_ddr_latency.sv
// DDR read latency descriptor with link query port and lookup
//
// Functional notes
// RULE1 - Byte zero returns the table identifier
// RULE2 - Byte one returns following byte count
// RULE3 - Header row starts with ASCII F, C
// RULE4 - Header lists fast DDR read opcodes
// RULE5 - Header lists dual DDR read opcodes
// RULE6 - Header lists quad DDR read opcodes
// RULE7 - Each row starts with frequency limit
// RULE8 - Code 11b: dummy 1, 2, 3
// RULE9 - Code 00b: dummy 2, 4, 6
// RULE10 - Code 01b: dummy 4, 5, 7
// RULE11 - Code 10b: dummy 5, 6, 8
// RULE12 - Mode cycles 4, 2, 1 always
// RULE13 - Host picks row, code, waits cycles
`timescale 1ns/1ns
module lct_ddr_latency
  import lct_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic sck_i,
  input wire logic lk_rd_i,
  input wire logic [LCT_AW-1:0] lk_addr_i,
  output logic [7:0] lk_rdata_o,
  output logic lk_rvalid_o,
  output logic lk_busy_o,
  input wire logic lu_valid_i,
  input wire logic [7:0] lu_opcode_i,
  input wire logic [1:0] lu_code_i,
  output logic lu_done_o,
  output logic lu_hit_o,
  output logic [7:0] lu_freq_o,
  output logic [7:0] lu_mode_o,
  output logic [7:0] lu_dummy_o
);

  // ***************************************************
  // Declarations
  // ***************************************************
  logic req_tgl_q;
  logic [LCT_AW-1:0] addr_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_seen_q;
  logic ack_new;
  logic req_s1_q;
  logic req_s2_q;
  logic req_seen_q;
  logic req_new;
  logic ack_tgl_q;
  logic [7:0] rdata_q;
  logic [7:0] rom_data;
  logic rom_en;
  lct_rd_t st_q;
  lct_cmd_t cmd;
  logic [LCT_NROWS-1:0] row_hit;
  logic [7:0] row_freq [LCT_NROWS];
  logic [7:0] row_mode [LCT_NROWS];
  logic [7:0] row_dum [LCT_NROWS];
  logic sel_hit;
  logic [7:0] sel_freq;
  logic [7:0] sel_mode;
  logic [7:0] sel_dum;

  // ***************************************************
  // Link side, serial clock domain
  // ***************************************************
  // Take one query at a time; a request while busy is ignored
  always_ff @(posedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_tgl_q <= 1'b0;
      addr_q <= '0;
    end else if (lk_rd_i && !lk_busy_o) begin
      req_tgl_q <= ~req_tgl_q;
      addr_q <= lk_addr_i;
    end
  end

  // Busy from a taken query until its answer lands
  always_ff @(posedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lk_busy_o <= 1'b0;
    end else if (lk_rd_i && !lk_busy_o) begin
      lk_busy_o <= 1'b1;
    end else if (ack_new) begin
      lk_busy_o <= 1'b0;
    end
  end

  // Answer toggle crossing into the serial clock domain
  always_ff @(posedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_seen_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_seen_q <= ack_s2_q;
    end
  end

  assign ack_new = ack_s2_q != ack_seen_q;

  // Answer byte; rdata_q is frozen while the toggle travels
  always_ff @(posedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lk_rdata_o <= 8'h00;
      lk_rvalid_o <= 1'b0;
    end else begin
      lk_rvalid_o <= ack_new;
      if (ack_new) begin
        lk_rdata_o <= rdata_q;
      end
    end
  end

  // ***************************************************
  // Query engine, system clock domain
  // ***************************************************
  // Request toggle crossing into the system clock domain
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
    end
  end

  assign req_new = req_s2_q != req_seen_q;
  assign rom_en = (st_q == LCT_RD_IDLE) && req_new;

  // Fetch sequencer: start the read, then return the byte
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= LCT_RD_IDLE;
      req_seen_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      case (st_q)
        LCT_RD_IDLE: begin
          if (req_new) begin
            req_seen_q <= req_s2_q;
            st_q <= LCT_RD_FETCH;
          end
        end
        LCT_RD_FETCH: begin
          rdata_q <= rom_data;
          ack_tgl_q <= ~ack_tgl_q;
          st_q <= LCT_RD_IDLE;
        end
        default: begin
          st_q <= LCT_RD_IDLE;
        end
      endcase
    end
  end

  // RULE1 identifier byte, RULE2 length, RULE3 to RULE7 table bytes
  lct_rom u_rom (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .en_i(rom_en),
    .addr_i(addr_q),
    .data_o(rom_data)
  );

  // ***************************************************
  // Latency lookup
  // ***************************************************
  // Sort the opcode into its command column
  always_comb begin
    case (lu_opcode_i)
      LCT_OP_FAST3, LCT_OP_FAST4: cmd = LCT_CMD_FAST;
      LCT_OP_DUAL3, LCT_OP_DUAL4: cmd = LCT_CMD_DUAL;
      LCT_OP_QUAD3, LCT_OP_QUAD4: cmd = LCT_CMD_QUAD;
      default: cmd = LCT_CMD_NONE;
    endcase
  end

  // RULE8 RULE9 RULE10 RULE11 per-row match on latency code
  // RULE12 mode column read from the same row
  for (genvar k = 0; k < LCT_NROWS; k++) begin : g_row
    localparam int BASE = LCT_ROW0 + k * LCT_ROWLEN;
    logic [1:0] ci;
    assign ci = (cmd == LCT_CMD_NONE) ? 2'b00 : cmd;
    assign row_hit[k] =
      LCT_ROM[BASE + LCT_FLD_CODE] == {6'h00, lu_code_i};
    assign row_freq[k] = LCT_ROM[BASE + LCT_FLD_FREQ];
    assign row_mode[k] =
      LCT_ROM[BASE + LCT_FLD_MODE + LCT_CMD_STRIDE * int'(ci)];
    assign row_dum[k] =
      LCT_ROM[BASE + LCT_FLD_DUM + LCT_CMD_STRIDE * int'(ci)];
  end

  // Pick the matching row; the row holds the dummy counts
  always_comb begin
    sel_hit = 1'b0;
    sel_freq = 8'h00;
    sel_mode = 8'h00;
    sel_dum = 8'h00;
    for (int k = 0; k < LCT_NROWS; k++) begin
      if (row_hit[k] && cmd != LCT_CMD_NONE) begin
        sel_hit = 1'b1;
        sel_freq = row_freq[k];
        sel_mode = row_mode[k];
        sel_dum = row_dum[k];
      end
    end
  end

  // Registered answer, one cycle after the request
  // Unknown opcodes answer with no hit and zero counts
  // The host waits the mode plus dummy cycles given here
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lu_done_o <= 1'b0;
      lu_hit_o <= 1'b0;
      lu_freq_o <= 8'h00;
      lu_mode_o <= 8'h00;
      lu_dummy_o <= 8'h00;
    end else begin
      lu_done_o <= lu_valid_i;
      if (lu_valid_i) begin
        lu_hit_o <= sel_hit;
        lu_freq_o <= sel_freq;
        lu_mode_o <= sel_mode;
        lu_dummy_o <= sel_dum;
      end
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  sequence s_fetch(logic [5:0] off);
    st_q == LCT_RD_FETCH && addr_q == off;
  endsequence

  property p_byte(logic [5:0] off, logic [7:0] val);
    @(posedge mclk_i) disable iff (!resetn_i)
    s_fetch(off) |=> rdata_q == val;
  endproperty

  property p_row(logic [1:0] c, logic [7:0] df, logic [7:0] dd,
                 logic [7:0] dq);
    @(posedge mclk_i) disable iff (!resetn_i)
    lu_valid_i && lu_code_i == c && cmd != LCT_CMD_NONE
    |=> lu_done_o && lu_hit_o &&
        lu_dummy_o == (($past(cmd) == LCT_CMD_FAST) ? df :
                       ($past(cmd) == LCT_CMD_DUAL) ? dd : dq);
  endproperty

  a_pid_byte: assert property ( // RULE1
    p_byte(LCT_OFF_PID, 8'h9a))
    else $error("identifier byte wrong");

  a_len_byte: assert property ( // RULE2
    p_byte(LCT_OFF_LEN, 8'h2a))
    else $error("length byte wrong");

  a_hdr_ascii: assert property ( // RULE3
    @(posedge mclk_i) disable iff (!resetn_i)
    s_fetch(LCT_OFF_HF) or s_fetch(LCT_OFF_HC)
    |=> rdata_q == (($past(addr_q) == LCT_OFF_HF) ? 8'h46 : 8'h43))
    else $error("header label byte wrong");

  a_fast_ops: assert property ( // RULE4
    @(posedge mclk_i) disable iff (!resetn_i)
    s_fetch(LCT_OFF_FAST3) or s_fetch(LCT_OFF_FAST4)
    |=> rdata_q == (($past(addr_q) == LCT_OFF_FAST3) ? 8'h0d : 8'h0e))
    else $error("fast opcode byte wrong");

  a_dual_ops: assert property ( // RULE5
    @(posedge mclk_i) disable iff (!resetn_i)
    s_fetch(LCT_OFF_DUAL3) or s_fetch(LCT_OFF_DUAL4)
    |=> rdata_q == (($past(addr_q) == LCT_OFF_DUAL3) ? 8'hbd : 8'hbe))
    else $error("dual opcode byte wrong");

  a_quad_ops: assert property ( // RULE6
    @(posedge mclk_i) disable iff (!resetn_i)
    s_fetch(LCT_OFF_QUAD3) or s_fetch(LCT_OFF_QUAD4)
    |=> rdata_q == (($past(addr_q) == LCT_OFF_QUAD3) ? 8'hed : 8'hee))
    else $error("quad opcode byte wrong");

  a_row_freq: assert property ( // RULE7
    @(posedge mclk_i) disable iff (!resetn_i)
    s_fetch(LCT_OFF_ROW2) or s_fetch(LCT_OFF_ROW3) or
    s_fetch(LCT_OFF_ROW4) or s_fetch(LCT_OFF_ROW5)
    |=> rdata_q == (($past(addr_q) == LCT_OFF_ROW2) ? 8'h32 : 8'h42))
    else $error("row frequency byte wrong");

  a_code3_dummy: assert property ( // RULE8
    p_row(2'b11, 8'h01, 8'h02, 8'h03))
    else $error("code 11b dummy count wrong");

  a_code0_dummy: assert property ( // RULE9
    p_row(2'b00, 8'h02, 8'h04, 8'h06))
    else $error("code 00b dummy count wrong");

  a_code1_dummy: assert property ( // RULE10
    p_row(2'b01, 8'h04, 8'h05, 8'h07))
    else $error("code 01b dummy count wrong");

  a_code2_dummy: assert property ( // RULE11
    p_row(2'b10, 8'h05, 8'h06, 8'h08))
    else $error("code 10b dummy count wrong");

  a_mode_cycles: assert property ( // RULE12
    @(posedge mclk_i) disable iff (!resetn_i)
    lu_valid_i && cmd != LCT_CMD_NONE
    |=> lu_mode_o == (($past(cmd) == LCT_CMD_FAST) ? 8'h04 :
                      ($past(cmd) == LCT_CMD_DUAL) ? 8'h02 : 8'h01))
    else $error("mode cycle count wrong");

  a_fetch_reply: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    rom_en |=> st_q == LCT_RD_FETCH ##1
      (st_q == LCT_RD_IDLE && $changed(ack_tgl_q)))
    else $error("query answer not returned in two cycles");

  a_busy_refuse: assert property (
    @(posedge sck_i) disable iff (!resetn_i)
    lk_rd_i && lk_busy_o |=> $stable(req_tgl_q) && $stable(addr_q))
    else $error("query taken while busy");

  // Answer strobe stands a single link cycle
  a_rvalid_pulse: assert property (
    @(posedge sck_i) disable iff (!resetn_i)
    lk_rvalid_o |=> !lk_rvalid_o)
    else $error("answer strobe longer than one cycle");

  // Busy is already low while the answer strobe stands
  a_busy_drop: assert property (
    @(posedge sck_i) disable iff (!resetn_i)
    lk_rvalid_o |-> !lk_busy_o)
    else $error("busy still high with the answer");

  // Unknown opcode answers as a miss with zero counts
  a_miss_zero: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    lu_valid_i && cmd == LCT_CMD_NONE
    |=> lu_done_o && !lu_hit_o && lu_mode_o == 8'h00 &&
        lu_dummy_o == 8'h00)
    else $error("unknown opcode not answered as a miss");

endmodule // lct_ddr_latency

// ===== tb/lct_host_model.sv
// Host side reader of the descriptor over the link query port
`timescale 1ns/1ns
module lct_host_model (
  output logic sck_o,
  output logic lk_rd_o,
  output logic [5:0] lk_addr_o,
  input wire logic [7:0] lk_rdata_i,
  input wire logic lk_rvalid_i,
  input wire logic lk_busy_i
);
  // When set, the request stays up through the busy time
  bit hold_rd = 1'b0;

  // Link clock idles low, address idles scrambled
  initial begin
    sck_o = 1'b0;
    lk_rd_o = 1'b0;
    lk_addr_o = 6'h15;
  end

  // One link clock period of 6 ns
  task automatic tick();
    #3 sck_o = 1'b1;
    #3 sck_o = 1'b0;
  endtask

  task automatic query(input logic [5:0] addr, output logic [7:0] data,
                       output bit ok);
    int n;
    bit busy_seen;
    n = 0;
    lk_addr_o = addr;
    lk_rd_o = 1'b1;
    tick();
    // Request released unless hold_rd is set; stale address would be a hazard, so invert it
    lk_rd_o = hold_rd;
    lk_addr_o = ~addr;
    busy_seen = (lk_busy_i === 1'b1);
    while (lk_rvalid_i !== 1'b1 && n < 20) begin
      tick();
      busy_seen |= (lk_busy_i === 1'b1);
      n++;
    end
    data = lk_rdata_i;
    ok = busy_seen && (lk_rvalid_i === 1'b1) && (lk_busy_i === 1'b0);
    lk_rd_o = 1'b0;
    tick();
    // Answer strobe lasts a single link cycle, no query was queued
    ok &= (lk_rvalid_i === 1'b0) && (lk_busy_i === 1'b0);
  endtask
endmodule // lct_host_model

// ===== tb/testbench.sv
// Self-checking bench for the DDR read latency descriptor
`timescale 1ns/1ns
module testbench;
  typedef struct {
    logic [1:0] code;
    logic [7:0] freq;
    logic [7:0] df;
    logic [7:0] dd;
    logic [7:0] dq;
  } lct_tb_row_t;

  // ***************************************************
  // Signals and expected tables
  // ***************************************************
  logic mclk_i, resetn_i, sck, lk_rd, lk_rvalid, lk_busy;
  logic lu_valid, lu_done, lu_hit;
  logic [5:0] lk_addr;
  logic [7:0] lk_rdata, lu_opcode, lu_freq, lu_mode, lu_dummy;
  logic [1:0] lu_code;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] exp_b [64];
  logic [7:0] ops [6] = '{8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee};
  logic [7:0] hdr [12] = '{8'h9a, 8'h2a, 8'h05, 8'h08, 8'h46, 8'h43,
                           8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee};
  lct_tb_row_t rows [4] = '{
    '{2'b11, 8'h32, 8'h01, 8'h02, 8'h03},
    '{2'b00, 8'h42, 8'h02, 8'h04, 8'h06},
    '{2'b01, 8'h42, 8'h04, 8'h05, 8'h07},
    '{2'b10, 8'h42, 8'h05, 8'h06, 8'h08}
  };

  lct_ddr_latency u_dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .sck_i(sck),
    .lk_rd_i(lk_rd), .lk_addr_i(lk_addr), .lk_rdata_o(lk_rdata),
    .lk_rvalid_o(lk_rvalid), .lk_busy_o(lk_busy),
    .lu_valid_i(lu_valid), .lu_opcode_i(lu_opcode), .lu_code_i(lu_code),
    .lu_done_o(lu_done), .lu_hit_o(lu_hit), .lu_freq_o(lu_freq),
    .lu_mode_o(lu_mode), .lu_dummy_o(lu_dummy)
  );

  lct_host_model u_host (
    .sck_o(sck), .lk_rd_o(lk_rd), .lk_addr_o(lk_addr),
    .lk_rdata_i(lk_rdata), .lk_rvalid_i(lk_rvalid), .lk_busy_i(lk_busy)
  );

  // ***************************************************
  // Clock, timeout and reporting
  // ***************************************************
  // System clock, 4 ns period
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // Cut a hang short
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Lookup outputs in one call
  task automatic check_lu(logic d, logic h, logic [7:0] f, logic [7:0] m,
                          logic [7:0] y);
    check("lu_done", {7'h00, d}, {7'h00, lu_done});
    check("lu_hit", {7'h00, h}, {7'h00, lu_hit});
    check("lu_freq", f, lu_freq);
    check("lu_mode", m, lu_mode);
    check("lu_dummy", y, lu_dummy);
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    logic [7:0] d;
    bit ok;
    int c;
    exp_b = '{default: 8'hff};
    for (int i = 0; i < 12; i++) begin
      exp_b[i] = hdr[i];
    end
    for (int r = 0; r < 4; r++) begin
      exp_b[12+8*r] = rows[r].freq;
      exp_b[13+8*r] = {6'h00, rows[r].code};
      exp_b[14+8*r] = 8'h04;
      exp_b[15+8*r] = rows[r].df;
      exp_b[16+8*r] = 8'h02;
      exp_b[17+8*r] = rows[r].dd;
      exp_b[18+8*r] = 8'h01;
      exp_b[19+8*r] = rows[r].dq;
    end
    resetn_i = 1'b0;
    lu_valid = 1'b0;
    lu_opcode = 8'h00;
    lu_code = 2'b00;
    repeat (10) @(negedge mclk_i);
    resetn_i = 1'b1;
    @(negedge mclk_i);
    check_lu(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    check("lk_rvalid", 8'h00, {7'h00, lk_rvalid});
    // Unknown opcode, then every opcode and code back to back
    lu_valid = 1'b1;
    lu_opcode = 8'h0b;
    @(negedge mclk_i);
    check_lu(1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
    foreach (rows[r]) begin
      for (int i = 0; i < 6; i++) begin
        lu_opcode = ops[i];
        lu_code = rows[r].code;
        c = i / 2;
        @(negedge mclk_i);
        check_lu(1'b1, 1'b1, rows[r].freq, (c == 0) ? 8'h04 :
          (c == 1) ? 8'h02 : 8'h01, (c == 0) ? rows[r].df :
          (c == 1) ? rows[r].dd : rows[r].dq);
      end
    end
    // Strobe drops, results hold
    lu_valid = 1'b0;
    @(negedge mclk_i);
    check_lu(1'b0, 1'b1, 8'h42, 8'h01, 8'h08);
    // Host at 60 MHz takes the first row fast enough
    lu_valid = 1'b1;
    lu_opcode = 8'hed;
    c = -1;
    foreach (rows[r]) begin
      lu_code = rows[r].code;
      @(negedge mclk_i);
      if (c < 0 && lu_freq >= 8'h3c) begin
        c = r;
      end
    end
    lu_valid = 1'b0;
    @(negedge mclk_i);
    check("host_row", 8'h01, c[7:0]);
    // Every descriptor byte and the unused space over the link
    for (int a = 0; a < 64; a++) begin
      u_host.query(a[5:0], d, ok);
      check("lk_rdata", exp_b[a], d);
      check("lk_handshake", 8'h01, {7'h00, ok});
    end
    // A request held through the busy time is refused, not queued
    u_host.hold_rd = 1'b1;
    u_host.query(6'h05, d, ok);
    u_host.hold_rd = 1'b0;
    check("lk_rdata_hold", 8'h43, d);
    check("lk_refused", 8'h01, {7'h00, ok});
    // Reset in mid-run clears every output
    lu_valid = 1'b1;
    lu_opcode = 8'hed;
    lu_code = 2'b01;
    @(negedge mclk_i);
    resetn_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    check_lu(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    check("lk_rdata_rst", 8'h00, lk_rdata);
    resetn_i = 1'b1;
    @(negedge mclk_i);
    check_lu(1'b1, 1'b1, 8'h42, 8'h01, 8'h07);
    lu_valid = 1'b0;
    u_host.query(6'h00, d, ok);
    check("lk_rdata_pid", 8'h9a, d);
    give_verdict();
  end
endmodule // testbench
